// ---- hdl/swfo_pkg.sv ----
// Constants and types shared by the switch forwarding and ordering block
package swfo_pkg;
  localparam int NPORT = 6;
  localparam int PW = 3;
  localparam int TS_W = 16;
  localparam int SZ_W = 9;
  localparam int QD = 4;
  localparam int QA = 2;
  localparam int HP = 0;
  localparam int HNP = 1;
  localparam int HCP = 2;
  localparam logic [PW-1:0] UP_PORT = 3'h0;
  localparam logic [PW-1:0] PAIR_PORT = 3'h1;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CUT = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_TS = 8'h0C;
  localparam int CTRL_RO_DIS_BIT = 0;
  localparam int CUT_DIS_BIT = 0;
  localparam logic CUT_DIS_RST = 1'b1;
  // Decoupler: one maximum packet of 2112 bytes in 8-byte words
  localparam int DEC_BYTES = 2112;
  localparam int WORD_BYTES = 8;
  localparam int DEC_WORDS = DEC_BYTES / WORD_BYTES;
  localparam int DEC_CW = $clog2(DEC_WORDS + 1);
  localparam int DEC_LAT_MAX = 5;
  localparam logic [2:0] DEC_CT_CYC = 3'h3;
  // Header type field groups
  localparam logic [3:0] TY_MEM_H = 4'h0;
  localparam logic [4:0] TY_IO = 5'h02;
  localparam logic [3:0] TY_CFG_H = 4'h2;
  localparam logic [4:0] TY_TCFG = 5'h1B;
  localparam logic [3:0] TY_CPL_H = 4'h5;
  localparam logic [1:0] TY_MSG_H = 2'h2;
  localparam logic [2:0] RR_ROOT = 3'h0;
  localparam logic [2:0] RR_ADDR = 3'h1;
  localparam logic [2:0] RR_ID = 3'h2;
  localparam logic [2:0] RR_BCAST = 3'h3;
  localparam logic [2:0] RR_LOCAL = 3'h4;
  localparam logic [2:0] RR_GATHER = 3'h5;
  localparam logic [7:0] MSG_PME_TO_ACK = 8'h1B;

  typedef enum logic [2:0] {CLS_P, CLS_NP, CLS_CP, CLS_INS_P, CLS_INS_CP} swfo_cls_t;
  typedef enum logic [2:0] {RT_ADDR32, RT_ADDR64, RT_ID, RT_ROOT, RT_BCAST, RT_LOCAL, RT_GATHER, RT_BAD} swfo_route_t;
  typedef struct packed {logic [TS_W-1:0] ts; logic [PW-1:0] dest; logic [SZ_W-1:0] size; logic ro; logic done;} swfo_desc_t;
  typedef struct packed {swfo_desc_t [QD-1:0] ent; logic [QA:0] wr; logic [QA:0] rd;} swfo_q_t;
  typedef struct packed {swfo_cls_t cls; logic [PW-1:0] dest; logic [SZ_W-1:0] size; logic ro;} swfo_enq_t;
  typedef struct packed {logic [PW-1:0] dest; logic [SZ_W-1:0] size; logic [TS_W-1:0] age;} swfo_head_t;
  typedef struct packed {logic [1:0] fmt; logic [4:0] typ; logic [7:0] msg;} swfo_hdr_t;
endpackage

// ---- hdl/swfo_core.sv ----
// Input frame buffer ordering, forwarding mode, decoupler and routing for one port
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module swfo_core #(
  parameter logic [swfo_pkg::PW-1:0] PORT_ID = 3'h0
) (
  input wire logic sys_clk, // Core clock, 50 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, words only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  output logic [31:0] hrdata, // AHB read data
  input wire logic enq_valid, // New packet header arrives
  input wire swfo_pkg::swfo_enq_t enq, // Class, destination, size, relaxed flag
  output logic enq_ready, // Target queue has room
  input wire logic rx_end, // Last packet fully received
  input wire logic [1:0] in_width, // Ingress width code, log2 lanes
  input wire logic [swfo_pkg::NPORT-1:0][1:0] eg_width, // Egress width code per port
  input wire logic pair_busy_in, // Pair transfer running elsewhere
  output logic [2:0] head_valid, // Dispatchable logical heads
  output swfo_pkg::swfo_head_t [2:0] head_info, // Per head destination, size, age
  input wire logic [2:0] disp, // Scheduler takes a head
  output logic tx_word, // Egress word this cycle
  output logic tx_last, // Last egress word
  output logic [swfo_pkg::PW-1:0] tx_dest, // Egress port of running packet
  output logic pair_active, // Pair transfer running here
  input wire logic dec_fill, // Word into decoupler
  input wire logic dec_fill_last, // Last word into decoupler
  output logic dec_fill_rdy, // Decoupler accepts a word
  input wire logic dec_drain, // Word out of decoupler
  input wire logic dec_drain_last, // Last word out of decoupler
  output logic dec_drain_ok, // Decoupler may be drained
  input wire logic rt_valid, // Header to classify
  input wire swfo_pkg::swfo_hdr_t rt_hdr, // Format, type, message code
  input wire logic rt_src_down, // Received on a downstream port
  input wire logic [1:0] rt_src_stack, // Receiving stack
  input wire logic [1:0] rt_dst_stack, // Target stack
  output logic rt_out_v, // Classification valid
  output swfo_pkg::swfo_route_t rt_kind, // Routing method
  output logic rt_self // Route-to-self transfer
);
  typedef struct packed {
    logic [swfo_pkg::TS_W-1:0] ts;
    swfo_pkg::swfo_q_t [2:0] q;
    swfo_pkg::swfo_desc_t insp;
    swfo_pkg::swfo_desc_t inscp;
    logic insp_v;
    logic inscp_v;
    logic [1:0] last_q;
    logic [swfo_pkg::QA-1:0] last_i;
    logic last_v;
    logic tx_act;
    logic [swfo_pkg::SZ_W-1:0] tx_cnt;
    logic [swfo_pkg::PW-1:0] tx_dest;
    logic [swfo_pkg::DEC_CW-1:0] dec_cnt;
    logic [2:0] dec_age;
    logic dec_pkt;
    logic ro_dis;
    logic cut_dis;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic rt_v;
    logic rt_self;
    swfo_pkg::swfo_route_t rt_kind;
  } swfo_st_t;

  swfo_st_t s_q, s_d;
  logic [1:0] rsync_q;
  logic rst_n_s;
  swfo_pkg::swfo_desc_t [2:0] qh, hd;
  logic [2:0] qp, pr, tv, go, pick;
  logic ip_sel, cp_sel, ro, ct_p;
  swfo_pkg::swfo_desc_t nd;
  int k;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Modular compare: a is older than b while residency stays below half the wrap
  function automatic logic older(input logic [swfo_pkg::TS_W-1:0] a, input logic [swfo_pkg::TS_W-1:0] b);
    logic [swfo_pkg::TS_W-1:0] diff;
    diff = a - b;
    return diff[swfo_pkg::TS_W-1];
  endfunction

  function automatic logic old_hd(input logic pa, input logic pb, input logic [swfo_pkg::TS_W-1:0] ta,
                                  input logic [swfo_pkg::TS_W-1:0] tb);
    return pa && (!pb || older(ta, tb));
  endfunction

  function automatic logic is_pair(input logic [swfo_pkg::PW-1:0] d);
    return (PORT_ID == swfo_pkg::UP_PORT && d == swfo_pkg::PAIR_PORT) ||
           (PORT_ID == swfo_pkg::PAIR_PORT && d == swfo_pkg::UP_PORT);
  endfunction

  function automatic logic qnz(input swfo_pkg::swfo_q_t q);
    return q.wr != q.rd;
  endfunction

  function automatic swfo_pkg::swfo_route_t route_of(input swfo_pkg::swfo_hdr_t h, input logic down);
    swfo_pkg::swfo_route_t r;
    r = swfo_pkg::RT_BAD;
    if (h.typ[4:1] == swfo_pkg::TY_MEM_H) r = h.fmt[0] ? swfo_pkg::RT_ADDR64 : swfo_pkg::RT_ADDR32;
    else if (h.typ == swfo_pkg::TY_IO) r = swfo_pkg::RT_ADDR32;
    else if (h.typ[4:1] == swfo_pkg::TY_CFG_H || h.typ[4:1] == swfo_pkg::TY_CPL_H) r = swfo_pkg::RT_ID;
    else if (h.typ == swfo_pkg::TY_TCFG) r = swfo_pkg::RT_ID;
    else if (h.typ[4:3] == swfo_pkg::TY_MSG_H) begin
      case (h.typ[2:0])
        swfo_pkg::RR_ROOT: r = swfo_pkg::RT_ROOT;
        swfo_pkg::RR_ADDR: r = h.fmt[0] ? swfo_pkg::RT_ADDR64 : swfo_pkg::RT_ADDR32;
        swfo_pkg::RR_ID: r = swfo_pkg::RT_ID;
        swfo_pkg::RR_BCAST: r = swfo_pkg::RT_BCAST;
        swfo_pkg::RR_LOCAL: r = swfo_pkg::RT_LOCAL;
        swfo_pkg::RR_GATHER: r = (down && h.msg == swfo_pkg::MSG_PME_TO_ACK) ? swfo_pkg::RT_GATHER
                                                                              : swfo_pkg::RT_BAD;
        default: r = swfo_pkg::RT_BAD;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rsync_q <= 2'h0;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n_s = rsync_q[1];

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ts = s_q.ts + 1'b1;
    for (int i = 0; i < 3; i++) begin
      qh[i] = s_q.q[i].ent[s_q.q[i].rd[swfo_pkg::QA-1:0]];
      qp[i] = qnz(s_q.q[i]);
    end
    // Insertion slots merge into their type head by age
    ip_sel = s_q.insp_v && (!qp[swfo_pkg::HP] || older(s_q.insp.ts, qh[swfo_pkg::HP].ts));
    cp_sel = s_q.inscp_v && (!qp[swfo_pkg::HCP] || older(s_q.inscp.ts, qh[swfo_pkg::HCP].ts));
    hd = qh;
    pr = qp;
    if (ip_sel) hd[swfo_pkg::HP] = s_q.insp;
    if (cp_sel) hd[swfo_pkg::HCP] = s_q.inscp;
    pr[swfo_pkg::HP] = qp[swfo_pkg::HP] || s_q.insp_v;
    pr[swfo_pkg::HCP] = qp[swfo_pkg::HCP] || s_q.inscp_v;
    ro = hd[swfo_pkg::HCP].ro && !s_q.ro_dis;
    tv[swfo_pkg::HP] = 1'b1;
    tv[swfo_pkg::HNP] = old_hd(pr[1], pr[0], hd[1].ts, hd[0].ts) ||
                        (old_hd(pr[0], pr[2], hd[0].ts, hd[2].ts) && ro &&
                         old_hd(pr[2], pr[1], hd[2].ts, hd[1].ts));
    // With no posted head there is nothing to pass, so a lone completion drains
    tv[swfo_pkg::HCP] = !pr[swfo_pkg::HP] ||
                        (old_hd(pr[1], pr[0], hd[1].ts, hd[0].ts) && old_hd(pr[2], pr[0], hd[2].ts, hd[0].ts)) ||
                        (ro && old_hd(pr[0], pr[2], hd[0].ts, hd[2].ts) &&
                         old_hd(pr[1], pr[2], hd[1].ts, hd[2].ts));
    for (int i = 0; i < 3; i++) begin
      // Cut through only when ingress keeps pace with egress
      go[i] = pr[i] && tv[i] && !s_q.tx_act &&
              (hd[i].done || (in_width >= eg_width[hd[i].dest] &&
                              !(is_pair(hd[i].dest) && s_q.cut_dis))) &&
              !(pair_busy_in && (hd[i].dest == swfo_pkg::UP_PORT || is_pair(hd[i].dest)));
    end
    head_valid = go;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (j != i && pr[j] && hd[j].dest == hd[i].dest && old_hd(pr[j], pr[i], hd[j].ts, hd[i].ts))
          head_valid[i] = 1'b0;
      end
    end
    pick = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (disp[i] && head_valid[i]) pick = 3'(1 << i);
    end
    // Egress streams one word per cycle, never paused
    if (s_q.tx_act) begin
      s_d.tx_cnt = s_q.tx_cnt - 1'b1;
      if (s_q.tx_cnt == 1) s_d.tx_act = 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      if (pick[i]) begin
        s_d.tx_act = 1'b1;
        s_d.tx_cnt = (hd[i].size == 0) ? swfo_pkg::SZ_W'(1) : hd[i].size;
        s_d.tx_dest = hd[i].dest;
        if (i == swfo_pkg::HP && ip_sel) s_d.insp_v = 1'b0;
        else if (i == swfo_pkg::HCP && cp_sel) s_d.inscp_v = 1'b0;
        else s_d.q[i].rd = s_q.q[i].rd + 1'b1;
      end
    end
    // Arrivals
    if (rx_end && s_q.last_v) s_d.q[s_q.last_q].ent[s_q.last_i].done = 1'b1;
    k = (enq.cls == swfo_pkg::CLS_NP) ? swfo_pkg::HNP : (enq.cls == swfo_pkg::CLS_CP) ? swfo_pkg::HCP : swfo_pkg::HP;
    case (enq.cls)
      swfo_pkg::CLS_INS_P: enq_ready = !s_q.insp_v;
      swfo_pkg::CLS_INS_CP: enq_ready = !s_q.inscp_v;
      default: enq_ready = s_q.q[k].wr != {~s_q.q[k].rd[swfo_pkg::QA], s_q.q[k].rd[swfo_pkg::QA-1:0]};
    endcase
    // Insertion packets are complete on entry and never wait for rx_end
    nd = '{ts: s_q.ts, dest: enq.dest, size: enq.size, ro: enq.ro, done: 1'b0};
    if (enq_valid && enq_ready) begin
      case (enq.cls)
        swfo_pkg::CLS_INS_P: begin
          s_d.insp = nd;
          s_d.insp.done = 1'b1;
          s_d.insp_v = 1'b1;
        end
        swfo_pkg::CLS_INS_CP: begin
          s_d.inscp = nd;
          s_d.inscp.done = 1'b1;
          s_d.inscp_v = 1'b1;
        end
        default: begin
          s_d.q[k].ent[s_q.q[k].wr[swfo_pkg::QA-1:0]] = nd;
          s_d.q[k].wr = s_q.q[k].wr + 1'b1;
          s_d.last_q = 2'(k);
          s_d.last_i = s_q.q[k].wr[swfo_pkg::QA-1:0];
          s_d.last_v = 1'b1;
        end
      endcase
    end
    // Bus decoupler: one packet, independent fill and drain
    // Words are counted only; the payload path sits outside this block
    dec_fill_rdy = !s_q.dec_pkt && s_q.dec_cnt < swfo_pkg::DEC_CW'(swfo_pkg::DEC_WORDS);
    dec_drain_ok = s_q.dec_cnt != 0 && (s_q.dec_pkt || s_q.dec_age >= swfo_pkg::DEC_CT_CYC);
    if (dec_fill && dec_fill_rdy) begin
      s_d.dec_cnt = s_d.dec_cnt + 1'b1;
      if (dec_fill_last) s_d.dec_pkt = 1'b1;
    end
    if (dec_drain && dec_drain_ok) begin
      s_d.dec_cnt = s_d.dec_cnt - 1'b1;
      if (dec_drain_last) s_d.dec_pkt = 1'b0;
    end
    if (s_d.dec_cnt == 0) s_d.dec_age = 3'h0;
    else if (s_q.dec_age < swfo_pkg::DEC_CT_CYC) s_d.dec_age = s_q.dec_age + 1'b1;
    // Routing classifier
    s_d.rt_v = rt_valid;
    if (rt_valid) begin
      s_d.rt_kind = route_of(rt_hdr, rt_src_down);
      s_d.rt_self = rt_src_stack == rt_dst_stack;
    end
    // AHB-Lite slave; read data loads in the address phase
    s_d.ap_wr = 1'b0;
    if (s_q.ap_wr) begin
      if (s_q.ap_addr == swfo_pkg::OFF_CTRL) s_d.ro_dis = hwdata[swfo_pkg::CTRL_RO_DIS_BIT];
      if (s_q.ap_addr == swfo_pkg::OFF_CUT) s_d.cut_dis = hwdata[swfo_pkg::CUT_DIS_BIT];
    end
    if (hsel && hready && htrans[1]) begin
      s_d.ap_wr = hwrite;
      s_d.ap_addr = haddr[7:0];
      case (haddr[7:0])
        swfo_pkg::OFF_CTRL: s_d.rdata = 32'(s_q.ro_dis);
        swfo_pkg::OFF_CUT: s_d.rdata = 32'(s_q.cut_dis);
        swfo_pkg::OFF_STAT: s_d.rdata = 32'({s_q.dec_cnt, s_q.dec_pkt, s_q.tx_act, s_q.inscp_v, s_q.insp_v,
                                             s_q.q[2].wr - s_q.q[2].rd, s_q.q[1].wr - s_q.q[1].rd,
                                             s_q.q[0].wr - s_q.q[0].rd});
        swfo_pkg::OFF_TS: s_d.rdata = 32'(s_q.ts);
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_q <= '0;
      s_q.cut_dis <= swfo_pkg::CUT_DIS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      head_info[i].dest = hd[i].dest;
      head_info[i].size = hd[i].size;
      head_info[i].age = s_q.ts - hd[i].ts;
    end
  end
  assign ct_p = in_width >= eg_width[hd[0].dest] && !(is_pair(hd[0].dest) && s_q.cut_dis);
  assign tx_word = s_q.tx_act;
  assign tx_last = s_q.tx_act && s_q.tx_cnt == 1;
  assign tx_dest = s_q.tx_dest;
  assign pair_active = s_q.tx_act && is_pair(s_q.tx_dest);
  assign rt_out_v = s_q.rt_v;
  assign rt_kind = s_q.rt_kind;
  assign rt_self = s_q.rt_self;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_s);

  // The first edge out of reset has no earlier count to compare
  ts_run_a: assert property ($past(rst_n_s) |-> s_q.ts == $past(s_q.ts) + 1'b1)
    else $error("timestamp stalled");
  sf_hold_a: assert property (head_valid[0] && !hd[0].done |-> ct_p) else $error("early forward");
  tx_cont_a: assert property (tx_word && !tx_last |=> tx_word && tx_dest == $past(tx_dest))
    else $error("egress interrupted");
  pair_dis_a: assert property (head_valid[0] && is_pair(hd[0].dest) && s_q.cut_dis |-> hd[0].done)
    else $error("pair cut through");
  pair_blk_a: assert property (pair_busy_in && head_valid[0] |-> hd[0].dest != swfo_pkg::UP_PORT)
    else $error("upstream not blocked");
  dec_lat_a: assert property (dec_fill && dec_fill_rdy && s_q.dec_cnt == 0 |-> ##[1:5] dec_drain_ok)
    else $error("decoupler latency");
  dec_cap_a: assert property (s_q.dec_cnt <= swfo_pkg::DEC_CW'(swfo_pkg::DEC_WORDS))
    else $error("decoupler overflow");
  np_order_a: assert property (head_valid[1] && pr[0] && !older(hd[1].ts, hd[0].ts) |-> ro)
    else $error("non-posted passed posted");
  strong_a: assert property (s_q.ro_dis && head_valid[2] |-> !old_hd(pr[0], pr[2], hd[0].ts, hd[2].ts))
    else $error("relaxed order used");
  same_dst_a: assert property (!(head_valid[0] && head_valid[2] && hd[0].dest == hd[2].dest))
    else $error("two heads to one port");
  lone_cp_a: assert property (pr == 3'h4 |-> tv[swfo_pkg::HCP]) else $error("lone completion held");
  ins_hold_a: assert property (s_q.insp_v && !(pick[0] && ip_sel) |=> s_q.insp_v && $stable(s_q.insp))
    else $error("insertion slot overwritten");
  run_start_a: assert property (pick != 3'h0 |=> tx_word) else $error("dispatch without egress");
  gather_a: assert property (rt_out_v && rt_kind == swfo_pkg::RT_GATHER |-> $past(rt_src_down))
    else $error("gather from upstream");
  ts_tag_a: assert property (enq_valid && enq_ready && enq.cls == swfo_pkg::CLS_INS_P
    |=> s_q.insp.ts == $past(s_q.ts)) else $error("bad arrival stamp");

  ct_c: cover property (pick != 0 && !hd[0].done);
  sf_c: cover property (pick[0] && hd[0].done ##1 tx_word [*3]);
  dec_c: cover property (dec_drain && dec_drain_ok && !s_q.dec_pkt);
  gat_c: cover property (rt_out_v && rt_kind == swfo_pkg::RT_GATHER);
  ins_c: cover property (pick[0] && ip_sel);
endmodule
`default_nettype wire

// ---- verif/swfo_sched_model.sv ----
// Scheduler stand-in: takes one dispatchable head, then waits out its egress run
`timescale 1ns/1ps
`default_nettype none
module swfo_sched_model (
  input wire logic sys_clk, // Core clock
  input wire logic rst_b, // Reset, active low
  input wire logic en, // Allow taking heads
  input wire logic slow, // Hesitate before each take
  input wire logic [2:0] head_valid, // Heads on offer
  input wire logic tx_last, // Egress run ends
  output logic [2:0] disp // Take one head
);
  logic busy_q;
  logic [1:0] wait_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      wait_q <= 2'h0;
      disp <= 3'h0;
    end else begin
      disp <= 3'h0;
      if (tx_last) begin
        busy_q <= 1'b0;
      end
      // One take per run; a new take only after the run's last word
      if (en && !busy_q && head_valid != 3'h0 && disp == 3'h0) begin
        if (slow && wait_q != 2'h3) begin
          wait_q <= wait_q + 2'h1;
        end else begin
          wait_q <= 2'h0;
          busy_q <= 1'b1;
          disp <= head_valid & (~head_valid + 3'h1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the forwarding and ordering block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b, hsel, hwrite, hreadyout, hresp, enq_valid, enq_ready, rx_end, pair_busy_in, tx_word, tx_last;
  logic pair_active, dec_fill, dec_fill_last, dec_fill_rdy, dec_drain, dec_drain_last, dec_drain_ok;
  logic rt_valid, rt_src_down, rt_out_v, rt_self, run_en, slow, pa;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, in_width, rt_src_stack, rt_dst_stack;
  logic [2:0] hsize, head_valid, disp, tx_dest;
  logic [5:0][1:0] eg_width;
  swfo_pkg::swfo_enq_t enq;
  swfo_pkg::swfo_head_t [2:0] head_info;
  swfo_pkg::swfo_hdr_t rt_hdr;
  swfo_pkg::swfo_route_t rt_kind;
  int errors, num_checks, runs, len;
  logic [2:0] od[8];
  int ol[8];
  always #10 sys_clk = ~sys_clk;
  swfo_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .enq_valid(enq_valid), .enq(enq), .enq_ready(enq_ready), .rx_end(rx_end), .in_width(in_width),
    .eg_width(eg_width), .pair_busy_in(pair_busy_in), .head_valid(head_valid), .head_info(head_info),
    .disp(disp), .tx_word(tx_word), .tx_last(tx_last), .tx_dest(tx_dest), .pair_active(pair_active),
    .dec_fill(dec_fill), .dec_fill_last(dec_fill_last), .dec_fill_rdy(dec_fill_rdy), .dec_drain(dec_drain),
    .dec_drain_last(dec_drain_last), .dec_drain_ok(dec_drain_ok), .rt_valid(rt_valid), .rt_hdr(rt_hdr),
    .rt_src_down(rt_src_down), .rt_src_stack(rt_src_stack), .rt_dst_stack(rt_dst_stack), .rt_out_v(rt_out_v),
    .rt_kind(rt_kind), .rt_self(rt_self));
  swfo_sched_model sched (.sys_clk(sys_clk), .rst_b(rst_b), .en(run_en), .slow(slow), .head_valid(head_valid),
    .tx_last(tx_last), .disp(disp));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Egress runs are recorded mid-cycle, clear of the launching edge
  always @(negedge sys_clk) begin
    if (tx_word === 1'b1) begin
      len++;
      pa |= pair_active;
      if (tx_last === 1'b1) begin
        od[runs[2:0]] = tx_dest;
        ol[runs[2:0]] = len;
        runs++;
        len = 0;
      end
    end else if (len != 0) begin
      chk(len, 0);
      len = 0;
    end
  end
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Leaves enq_valid high so that pushes can run back to back
  task automatic push(input swfo_pkg::swfo_cls_t c, input logic [2:0] d, input logic [8:0] s, input logic ro);
    enq <= '{cls: c, dest: d, size: s, ro: ro};
    enq_valid <= 1'b1;
    do @(posedge sys_clk); while (enq_ready !== 1'b1);
  endtask
  task automatic drain(input int k);
    run_en <= 1'b1;
    while (runs < k) @(posedge sys_clk);
    run_en <= 1'b0;
  endtask
  task automatic fin_rx;
    @(posedge sys_clk);
    rx_end <= 1'b1;
    @(posedge sys_clk);
    rx_end <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_regs;
    logic [31:0] r, t0;
    ahb(1'b0, swfo_pkg::OFF_CTRL, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b0, swfo_pkg::OFF_CUT, 32'h0, r);
    chk(r, 32'h1);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF, r);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b0, swfo_pkg::OFF_TS, 32'h0, t0);
    repeat (10) @(posedge sys_clk);
    ahb(1'b0, swfo_pkg::OFF_TS, 32'h0, r);
    chk({16'h0, r[15:0] - t0[15:0]}, 32'hC);
  endtask
  task automatic t_fwd;
    logic [31:0] r;
    push(swfo_pkg::CLS_P, 3'h2, 9'h3, 1'b0);
    enq_valid <= 1'b0;
    @(negedge sys_clk);
    chk(head_valid, 3'h1);
    chk(head_info[0].size, 9'h3);
    chk(head_info[0].age, 16'h1);
    drain(1);
    chk(ol[0], 3);
    in_width <= 2'h0;
    push(swfo_pkg::CLS_P, 3'h3, 9'h2, 1'b0);
    enq_valid <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(head_valid, 3'h0);
    fin_rx();
    chk(head_valid, 3'h1);
    @(posedge sys_clk);
    in_width <= 2'h3;
    drain(2);
    pa = 1'b0;
    push(swfo_pkg::CLS_P, swfo_pkg::PAIR_PORT, 9'h2, 1'b0);
    enq_valid <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(head_valid, 3'h0);
    fin_rx();
    drain(3);
    chk(pa, 1'b1);
    ahb(1'b1, swfo_pkg::OFF_CUT, 32'h0, r);
    pair_busy_in <= 1'b1;
    push(swfo_pkg::CLS_P, swfo_pkg::PAIR_PORT, 9'h1, 1'b0);
    enq_valid <= 1'b0;
    @(negedge sys_clk);
    chk(head_valid, 3'h0);
    @(posedge sys_clk);
    pair_busy_in <= 1'b0;
    @(negedge sys_clk);
    chk(head_valid, 3'h1);
    drain(4);
  endtask
  task automatic t_order;
    logic [31:0] r;
    runs = 0;
    push(swfo_pkg::CLS_NP, 3'h2, 9'h1, 1'b0);
    push(swfo_pkg::CLS_P, 3'h3, 9'h1, 1'b0);
    push(swfo_pkg::CLS_CP, 3'h4, 9'h1, 1'b1);
    enq_valid <= 1'b0;
    @(negedge sys_clk);
    chk(head_valid, 3'h7);
    @(posedge sys_clk);
    ahb(1'b1, swfo_pkg::OFF_CTRL, 32'h1, r);
    @(negedge sys_clk);
    chk(head_valid, 3'h3);
    @(posedge sys_clk);
    ahb(1'b1, swfo_pkg::OFF_CTRL, 32'h0, r);
    drain(3);
    push(swfo_pkg::CLS_P, 3'h2, 9'h1, 1'b0);
    push(swfo_pkg::CLS_NP, 3'h3, 9'h1, 1'b0);
    enq_valid <= 1'b0;
    @(negedge sys_clk);
    chk(head_valid, 3'h1);
    drain(5);
    runs = 0;
    slow <= 1'b1;
    push(swfo_pkg::CLS_NP, 3'h2, 9'h1, 1'b0);
    push(swfo_pkg::CLS_P, 3'h2, 9'h2, 1'b0);
    push(swfo_pkg::CLS_P, 3'h3, 9'h3, 1'b0);
    enq_valid <= 1'b0;
    drain(3);
    chk(ol[0], 1);
    chk(ol[1], 2);
    chk(od[2], 3'h3);
  endtask
  task automatic t_ins;
    push(swfo_pkg::CLS_INS_P, 3'h2, 9'h1, 1'b0);
    push(swfo_pkg::CLS_INS_CP, 3'h4, 9'h1, 1'b0);
    push(swfo_pkg::CLS_P, 3'h3, 9'h1, 1'b0);
    enq_valid <= 1'b0;
    enq.cls <= swfo_pkg::CLS_INS_P;
    @(negedge sys_clk);
    chk(enq_ready, 1'b0);
    chk(head_info[0].dest, 3'h2);
    drain(6);
    chk(od[4], 3'h3);
    chk(od[5], 3'h4);
  endtask
  task automatic t_dec;
    for (int i = 0; i < 6; i++) begin
      dec_fill <= 1'b1;
      dec_fill_last <= (i == 5);
      @(negedge sys_clk);
      if (i == 2) chk(dec_drain_ok, 1'b0);
      if (i == 3) chk(dec_drain_ok, 1'b1);
      @(posedge sys_clk);
    end
    dec_fill <= 1'b0;
    @(negedge sys_clk);
    chk(dec_fill_rdy, 1'b0);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      dec_drain <= 1'b1;
      dec_drain_last <= (i == 5);
    end
    @(posedge sys_clk);
    dec_drain <= 1'b0;
    @(negedge sys_clk);
    chk(dec_fill_rdy, 1'b1);
  endtask
  task automatic rtc(logic [1:0] f, logic [4:0] t, logic dn, logic [1:0] ds, swfo_pkg::swfo_route_t k);
    @(posedge sys_clk);
    rt_valid <= 1'b1;
    rt_hdr <= '{fmt: f, typ: t, msg: swfo_pkg::MSG_PME_TO_ACK};
    rt_src_down <= dn;
    rt_src_stack <= 2'h1;
    rt_dst_stack <= ds;
    @(posedge sys_clk);
    rt_valid <= 1'b0;
    @(negedge sys_clk);
    chk(rt_out_v, 1'b1);
    chk(rt_kind, k);
    chk(rt_self, ds == 2'h1);
  endtask
  initial begin
    {hsel, hwrite, enq_valid, rx_end, pair_busy_in, dec_fill, dec_fill_last, dec_drain} = '0;
    {dec_drain_last, rt_valid, rt_src_down, run_en, slow, pa, rst_b} = '0;
    {haddr, hwdata, htrans, rt_src_stack, rt_dst_stack} = '0;
    enq = '0;
    rt_hdr = '0;
    hsize = 3'h2;
    in_width = 2'h3;
    eg_width = '1;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_fwd();
    t_order();
    t_ins();
    t_dec();
    rtc(2'h0, 5'h00, 1'b1, 2'h2, swfo_pkg::RT_ADDR32);
    rtc(2'h1, 5'h00, 1'b1, 2'h2, swfo_pkg::RT_ADDR64);
    rtc(2'h2, 5'h1B, 1'b1, 2'h2, swfo_pkg::RT_ID);
    rtc(2'h1, 5'h10, 1'b1, 2'h2, swfo_pkg::RT_ROOT);
    rtc(2'h1, 5'h13, 1'b0, 2'h2, swfo_pkg::RT_BCAST);
    rtc(2'h1, 5'h14, 1'b1, 2'h1, swfo_pkg::RT_LOCAL);
    rtc(2'h1, 5'h15, 1'b1, 2'h2, swfo_pkg::RT_GATHER);
    rtc(2'h1, 5'h15, 1'b0, 2'h2, swfo_pkg::RT_BAD);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
